// ===== ddp_pkg.sv
// Shared constants and types for the descriptor prefetcher.
// Assumes a single clock domain and an APB-attached register file.
`default_nettype none

package ddp_pkg;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int DEPTH = 8;
	localparam int PTRW  = 3;
	localparam int CNTW  = 4;

	// ----------------------------------------
	// Register indices, byte address is index times four
	// ----------------------------------------
	localparam logic [5:0] IDX_CTRL = 6'h00;
	localparam logic [5:0] IDX_NLO  = 6'h01;
	localparam logic [5:0] IDX_NHI  = 6'h02;
	localparam logic [5:0] IDX_POLL = 6'h03;
	localparam logic [5:0] IDX_STAT = 6'h04;

	// ----------------------------------------
	// Control and status bit positions
	// ----------------------------------------
	localparam int CTL_RUN  = 0;
	localparam int CTL_POLL = 1;
	localparam int CTL_WIDE = 2;
	localparam int CTL_PARK = 4;
	localparam int STS_BUSY = 0;
	localparam int STS_WAIT = 1;
	localparam int STS_END  = 2;
	localparam int STS_CNT  = 8;

	// ----------------------------------------
	// Descriptor layout, one 256-bit beat
	// ----------------------------------------
	localparam int W_RADDR   = 0;
	localparam int W_WADDR   = 1;
	localparam int W_LEN     = 2;
	localparam int W_LINK    = 3;
	localparam int W_BYTES   = 4;
	localparam int W_STAT    = 5;
	localparam int W_CTRL    = 7;
	localparam int OWN_BIT   = 30;
	localparam int EARLY_BIT = 8;
	localparam logic [31:0] WB_BE = 32'hf0ff0000;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [31:0] CTRL_RST = 32'h00000000;
	localparam logic [31:0] NPTR_RST = 32'h00000000;
	localparam logic [31:0] POLL_RST = 32'h00000000;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_REQ  = 2'b01,
		ST_DATA = 2'b10,
		ST_POLL = 2'b11
	} ddp_fsm_t;

	typedef struct packed {
		logic [63:0] addr;
		logic [31:0] ctrl;
	} ddp_entry_t;

	typedef struct packed {
		logic [31:0] bytes;
		logic [7:0]  error;
		logic        early;
	} ddp_rsp_t;

	typedef struct packed {
		logic [31:0] raddr;
		logic [31:0] waddr;
		logic [31:0] len;
		logic [31:0] ctrl;
	} ddp_disp_t;

	typedef struct packed {
		logic [31:0]                 ctrl;
		logic [31:0]                 nlo;
		logic [31:0]                 nhi;
		logic [31:0]                 poll;
		logic                        ended;
		ddp_fsm_t                    fsm;
		logic [63:0]                 fptr;
		logic [31:0]                 timer;
		logic                        rd_req;
		logic                        dsp_valid;
		ddp_disp_t                   dsp;
		ddp_entry_t [DEPTH-1:0]      ent;
		logic [PTRW-1:0]             wp;
		logic [PTRW-1:0]             rp;
		logic [CNTW-1:0]             cnt;
		logic                        rsp_ready;
		logic                        wr_req;
		logic [63:0]                 wr_addr;
		logic [255:0]                wr_data;
		logic                        pready;
		logic                        pslverr;
		logic [31:0]                 prdata;
	} ddp_state_t;

endpackage

`default_nettype wire

// ===== ddp_prefetcher.sv
// Descriptor prefetcher: fetches linked descriptors, feeds the dispatcher,
// writes results back. Assumes memory ports and dispatcher share MCLK.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none

// Operation
// RL1: Next descriptor is fetched from the link address of the current one.
// RL2: Write back reports bytes actually moved; meaningless for memory-to-stream.
// RL3: Status bit 8 set on early end of packet at the write side.
// RL4: Status bits 7:0 carry the write-side sink error value.
// RL5: Control bit 30 is ownership; hardware owns while it is one.
// RL6: A fetched descriptor with ownership one is processed.
// RL7: Ownership zero: not processed, list ended or not yet ready.
// RL8: Each finished descriptor gets bytes, status and control written back.
// RL9: Write back clears the ownership bit, returning the descriptor.
// RL10: Descriptor addresses are buffered as deep as the dispatcher queue.
// RL11: Each dispatcher response pops one address and drives its write back.
// RL12: Software initialises descriptors aligned to the data width.
// RL13: Fetch via read port, write back via write port, queue in dispatcher.
// RL14: Control bits 31 and 29:0 pass to the dispatcher unchanged.
// RL15: Control at index 0, poll interval at 3, status at 4.
// RL16: Index 1 holds next address low, loaded by software first.
// RL17: Index 2 holds next address high, used only when wide addressing.
// RL18: With polling, both next-address registers track the latest link.
// RL19: Looping mode keeps ownership set on write back, otherwise cleared.
// RL20: Link at 0xC, bytes at 0x10, status at 0x14, control at 0x1C.
// RL21: With polling, an unowned descriptor is re-read after the interval.
// RL22: Fetch only while dispatcher queue and address buffer have space.
module ddp_prefetcher (
	// Clock and reset
	input  wire logic                 MCLK,
	input  wire logic                 RST,
	// APB register port
	input  wire logic                 PSEL,
	input  wire logic                 PENABLE,
	input  wire logic                 PWRITE,
	input  wire logic [7:0]           PADDR,
	input  wire logic [31:0]          PWDATA,
	output logic      [31:0]          PRDATA,
	output logic                      PREADY,
	output logic                      PSLVERR,
	// Descriptor read port
	output logic                      RD_REQ,
	output logic      [63:0]          RD_ADDR,
	input  wire logic                 RD_GNT,
	input  wire logic                 RD_VALID,
	input  wire logic [255:0]         RD_DATA,
	// Descriptor write-back port
	output logic                      WR_REQ,
	output logic      [63:0]          WR_ADDR,
	output logic      [255:0]         WR_DATA,
	output logic      [31:0]          WR_BE,
	input  wire logic                 WR_GNT,
	// Dispatcher descriptor and response
	output logic                      DSP_VALID,
	output ddp_pkg::ddp_disp_t        DSP_DESC,
	input  wire logic                 DSP_READY,
	input  wire logic                 RSP_VALID,
	input  wire ddp_pkg::ddp_rsp_t    RSP_INFO,
	output logic                      RSP_READY
);

	ddp_pkg::ddp_state_t s_r;
	ddp_pkg::ddp_state_t s_nxt;

	function automatic logic [31:0] word(input logic [255:0] d, input int i);
		word = d[32*i +: 32];
	endfunction

	function automatic logic [63:0] wide_addr(input logic wide, input logic [31:0] hi,
	                                          input logic [31:0] lo);
		wide_addr = {wide ? hi : 32'h00000000, lo};
	endfunction

	// ----------------------------------------
	// Decode of the fetched beat
	// ----------------------------------------
	logic        own;
	logic        got;
	logic        push;
	logic        pop;
	logic [63:0] link;
	logic [31:0] rd_ctrl;

	assign rd_ctrl = word(RD_DATA, ddp_pkg::W_CTRL);                 // RL20
	assign own     = rd_ctrl[ddp_pkg::OWN_BIT];                      // RL5
	assign got     = (s_r.fsm == ddp_pkg::ST_DATA) && RD_VALID;
	assign push    = got && own;                                     // RL6
	assign pop     = s_r.rsp_ready && RSP_VALID;                     // RL11
	assign link    = wide_addr(s_r.ctrl[ddp_pkg::CTL_WIDE], s_r.nhi,
	                           word(RD_DATA, ddp_pkg::W_LINK));      // RL1 RL17

	logic setup;
	logic access;
	logic hit;

	assign setup  = PSEL && !PENABLE && !s_r.pready;
	assign access = PSEL && PENABLE && s_r.pready;
	assign hit    = (PADDR[1:0] == 2'b00) && (PADDR[7:2] <= ddp_pkg::IDX_STAT);

	always_comb begin
		ddp_pkg::ddp_entry_t head;
		logic [31:0]         wb_ctrl;
		s_nxt   = s_r;
		head    = s_r.ent[s_r.rp];
		wb_ctrl = head.ctrl;

		// ----------------------------------------
		// APB slave, zero wait states
		// ----------------------------------------
		s_nxt.pready = setup;
		if (setup) begin
			s_nxt.pslverr = !hit;
			case (PADDR[7:2])                                        // RL15
				ddp_pkg::IDX_CTRL: s_nxt.prdata = s_r.ctrl;
				ddp_pkg::IDX_NLO:  s_nxt.prdata = s_r.nlo;           // RL16
				ddp_pkg::IDX_NHI:  s_nxt.prdata = s_r.nhi;           // RL17
				ddp_pkg::IDX_POLL: s_nxt.prdata = s_r.poll;
				ddp_pkg::IDX_STAT: begin
					s_nxt.prdata = 32'h00000000;
					s_nxt.prdata[ddp_pkg::STS_BUSY] = (s_r.fsm != ddp_pkg::ST_IDLE) ||
					                                  (s_r.cnt != '0);
					s_nxt.prdata[ddp_pkg::STS_WAIT] = (s_r.fsm == ddp_pkg::ST_POLL);
					s_nxt.prdata[ddp_pkg::STS_END]  = s_r.ended;
					s_nxt.prdata[ddp_pkg::STS_CNT +: ddp_pkg::CNTW] = s_r.cnt;
				end
				default: s_nxt.prdata = 32'h00000000;
			endcase
		end else begin
			s_nxt.pslverr = 1'b0;
		end
		if (access && PWRITE && !s_r.pslverr) begin
			case (PADDR[7:2])
				ddp_pkg::IDX_CTRL: begin
					// Bit 3 has no function in this block and reads zero
					s_nxt.ctrl = {27'h0000000, PWDATA[4], 1'b0, PWDATA[2:0]};
					// Starting picks up the software pointer afresh
					if (PWDATA[ddp_pkg::CTL_RUN] && !s_r.ctrl[ddp_pkg::CTL_RUN]) begin
						s_nxt.fptr  = wide_addr(PWDATA[ddp_pkg::CTL_WIDE], s_r.nhi, s_r.nlo);
						s_nxt.ended = 1'b0;
					end
				end
				ddp_pkg::IDX_NLO:  s_nxt.nlo  = PWDATA;                 // RL16
				ddp_pkg::IDX_NHI:  s_nxt.nhi  = PWDATA;
				ddp_pkg::IDX_POLL: s_nxt.poll = PWDATA;
				default: ;
			endcase
		end

		// ----------------------------------------
		// Dispatcher handshake
		// ----------------------------------------
		if (s_r.dsp_valid && DSP_READY) begin
			s_nxt.dsp_valid = 1'b0;
		end

		// ----------------------------------------
		// Fetch sequencer
		// ----------------------------------------
		case (s_r.fsm)
			ddp_pkg::ST_IDLE: begin
				// One fetch in flight, so a free slot now stays free
				if (s_nxt.ctrl[ddp_pkg::CTL_RUN] && !s_r.dsp_valid &&
				    (s_r.cnt < ddp_pkg::CNTW'(ddp_pkg::DEPTH))) begin   // RL22
					s_nxt.rd_req = 1'b1;                                 // RL13
					s_nxt.fsm    = ddp_pkg::ST_REQ;
				end
			end
			ddp_pkg::ST_REQ: begin
				if (RD_GNT) begin
					s_nxt.rd_req = 1'b0;
					s_nxt.fsm    = ddp_pkg::ST_DATA;
				end
			end
			ddp_pkg::ST_DATA: begin
				if (RD_VALID) begin
					s_nxt.fsm = ddp_pkg::ST_IDLE;
					if (own) begin
						s_nxt.ent[s_r.wp] = '{addr: s_r.fptr, ctrl: rd_ctrl};  // RL10
						s_nxt.wp          = s_r.wp + 1'b1;
						s_nxt.dsp_valid   = 1'b1;
						s_nxt.dsp.raddr   = word(RD_DATA, ddp_pkg::W_RADDR);
						s_nxt.dsp.waddr   = word(RD_DATA, ddp_pkg::W_WADDR);
						s_nxt.dsp.len     = word(RD_DATA, ddp_pkg::W_LEN);
						s_nxt.dsp.ctrl    = rd_ctrl;                   // RL14
						s_nxt.fptr        = link;                      // RL1
						if (s_r.ctrl[ddp_pkg::CTL_POLL]) begin
							s_nxt.nlo = link[31:0];                    // RL18
							s_nxt.nhi = link[63:32];
						end
					end else if (s_r.ctrl[ddp_pkg::CTL_POLL]) begin
						s_nxt.timer = s_r.poll;                        // RL21
						s_nxt.fsm   = ddp_pkg::ST_POLL;
					end else begin
						s_nxt.ctrl[ddp_pkg::CTL_RUN] = 1'b0;           // RL7
						s_nxt.ended                  = 1'b1;
					end
				end
			end
			ddp_pkg::ST_POLL: begin
				// Same pointer is fetched again once the wait runs out
				if (!s_nxt.ctrl[ddp_pkg::CTL_RUN] || (s_r.timer == 32'h00000000)) begin
					s_nxt.fsm = ddp_pkg::ST_IDLE;                      // RL21
				end else begin
					s_nxt.timer = s_r.timer - 32'h00000001;
				end
			end
			default: s_nxt.fsm = ddp_pkg::ST_IDLE;
		endcase

		// ----------------------------------------
		// Write back on each dispatcher response
		// ----------------------------------------
		wb_ctrl[ddp_pkg::OWN_BIT] = s_r.ctrl[ddp_pkg::CTL_PARK];      // RL9 RL19
		if (s_r.wr_req && WR_GNT) begin
			s_nxt.wr_req = 1'b0;
		end
		if (pop) begin
			s_nxt.rp      = s_r.rp + 1'b1;                             // RL11
			s_nxt.wr_req  = 1'b1;                                      // RL8
			s_nxt.wr_addr = head.addr;
			s_nxt.wr_data = 256'h0;
			s_nxt.wr_data[32*ddp_pkg::W_BYTES +: 32] = RSP_INFO.bytes; // RL2
			s_nxt.wr_data[32*ddp_pkg::W_STAT +: 8]   = RSP_INFO.error; // RL4
			s_nxt.wr_data[32*ddp_pkg::W_STAT + ddp_pkg::EARLY_BIT] = RSP_INFO.early;  // RL3
			s_nxt.wr_data[32*ddp_pkg::W_CTRL +: 32]  = wb_ctrl;
		end
		s_nxt.cnt = s_r.cnt + ddp_pkg::CNTW'(push) - ddp_pkg::CNTW'(pop);
		// Response taken only when the write port is free
		s_nxt.rsp_ready = !s_nxt.wr_req && !pop && (s_nxt.cnt != '0);
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			s_r       <= '0;
			s_r.ctrl  <= ddp_pkg::CTRL_RST;
			s_r.nlo   <= ddp_pkg::NPTR_RST;
			s_r.nhi   <= ddp_pkg::NPTR_RST;
			s_r.poll  <= ddp_pkg::POLL_RST;
			s_r.fsm   <= ddp_pkg::ST_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign PRDATA    = s_r.prdata;
	assign PREADY    = s_r.pready;
	assign PSLVERR   = s_r.pslverr;
	assign RD_REQ    = s_r.rd_req;
	assign RD_ADDR   = s_r.fptr;
	assign WR_REQ    = s_r.wr_req;
	assign WR_ADDR   = s_r.wr_addr;
	assign WR_DATA   = s_r.wr_data;
	assign WR_BE     = ddp_pkg::WB_BE;
	assign DSP_VALID = s_r.dsp_valid;
	assign DSP_DESC  = s_r.dsp;
	assign RSP_READY = s_r.rsp_ready;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);

	owned_go_a: assert property (push |=> DSP_VALID && DSP_DESC.ctrl == $past(rd_ctrl)) // RL6
		else $error("owned descriptor not passed on");
	unowned_stop_a: assert property (got && !own |=> !$rose(DSP_VALID) && // RL7
		s_r.cnt + {3'b000, $past(pop)} == $past(s_r.cnt))
		else $error("unowned descriptor was processed");
	link_follow_a: assert property (push |=> RD_ADDR[31:0] == $past(RD_DATA[127:96])) // RL1
		else $error("fetch pointer did not follow link");
	wb_owner_a: assert property (pop |=> WR_REQ && // RL9
		WR_DATA[224 + 30] == $past(s_r.ctrl[4]))
		else $error("ownership bit wrong on write back");
	wb_bytes_a: assert property (pop |=> WR_DATA[159:128] == $past(RSP_INFO.bytes)) // RL2
		else $error("byte count not written back");
	wb_status_a: assert property (pop |=> WR_DATA[167:160] == $past(RSP_INFO.error) && // RL4
		WR_DATA[168] == $past(RSP_INFO.early))
		else $error("status not written back");
	wb_target_a: assert property (pop |=> WR_ADDR == $past(s_r.ent[s_r.rp].addr)) // RL11
		else $error("write back aimed at wrong descriptor");
	fetch_space_a: assert property ($rose(RD_REQ) |-> !DSP_VALID && s_r.cnt < 4'h8) // RL22
		else $error("fetch started without room");
	poll_wait_a: assert property (got && !own && s_r.ctrl[1] |=> // RL21
		s_r.fsm == ddp_pkg::ST_POLL && s_r.timer == $past(s_r.poll))
		else $error("poll wait not armed");
	ended_flag_a: assert property (got && !own && !s_r.ctrl[1] |=> // RL7
		!s_r.ctrl[0] && s_r.ended)
		else $error("list end not recorded");
	wb_ctrl_a: assert property (pop |=> // RL14
		WR_DATA[255] == $past(s_r.ent[s_r.rp].ctrl[31]) &&
		WR_DATA[253:224] == $past(s_r.ent[s_r.rp].ctrl[29:0]))
		else $error("control not written back as fetched");
	latest_link_a: assert property (push && s_r.ctrl[1] |=> // RL18
		{s_r.nhi, s_r.nlo} == $past(link))
		else $error("next address registers not updated");
	depth_cap_a: assert property (s_r.cnt <= 4'h8) // RL10
		else $error("address buffer overflow");
	rsp_gap_a: assert property (pop |=> !RSP_READY) // RL11
		else $error("second response taken before write back");
	rd_hold_a: assert property (RD_REQ && !RD_GNT |=> RD_REQ) // RL13
		else $error("fetch request dropped before grant");
	rd_once_a: assert property (RD_REQ && RD_GNT |=> !RD_REQ) // RL13
		else $error("fetch request repeated after grant");
	dsp_hold_a: assert property (DSP_VALID && !DSP_READY |=> // RL13
		DSP_VALID && $stable(DSP_DESC))
		else $error("dispatcher descriptor changed while waiting");
	wr_hold_a: assert property (WR_REQ && !WR_GNT |=> // RL8
		WR_REQ && $stable(WR_ADDR) && $stable(WR_DATA))
		else $error("write back changed while waiting");
	apb_ready_a: assert property (PSEL && !PENABLE && !PREADY |=> PREADY) // RL15
		else $error("register access not answered");
	apb_pulse_a: assert property (PREADY |=> !PREADY) // RL15
		else $error("ready held past access");
	apb_unmapped_a: assert property (PSEL && !PENABLE && !PREADY && // RL15
		PADDR[7:2] > 6'h04 |=> PSLVERR && PRDATA == 32'h00000000)
		else $error("unmapped register access not refused");
	ctrl_read_a: assert property (PSEL && !PENABLE && !PREADY && PADDR == 8'h00 |=> // RL15
		PRDATA == $past(s_r.ctrl) && !PSLVERR)
		else $error("control read wrong");
	nlo_read_a: assert property (PSEL && !PENABLE && !PREADY && PADDR == 8'h04 |=> // RL16
		PRDATA == $past(s_r.nlo) && !PSLVERR)
		else $error("next address low read wrong");
	nhi_read_a: assert property (PSEL && !PENABLE && !PREADY && PADDR == 8'h08 |=> // RL17
		PRDATA == $past(s_r.nhi) && !PSLVERR)
		else $error("next address high read wrong");
	poll_read_a: assert property (PSEL && !PENABLE && !PREADY && PADDR == 8'h0c |=> // RL15
		PRDATA == $past(s_r.poll) && !PSLVERR)
		else $error("poll interval read wrong");
	nlo_write_a: assert property (PSEL && PENABLE && PREADY && PWRITE && // RL16
		PADDR == 8'h04 && !(push && s_r.ctrl[1]) |=> s_r.nlo == $past(PWDATA))
		else $error("next address low not written");
	ctrl_spare_a: assert property (s_r.ctrl[31:5] == 27'h0 && !s_r.ctrl[3]) // RL15
		else $error("unused control bits set");
	start_load_a: assert property (PSEL && PENABLE && PREADY && PWRITE && // RL16
		PADDR == 8'h00 && PWDATA[0] && !s_r.ctrl[0] && s_r.fsm == ddp_pkg::ST_IDLE |=>
		RD_ADDR[31:0] == $past(s_r.nlo))
		else $error("start did not load the first descriptor address");

endmodule // ddp_prefetcher

`default_nettype wire

// ===== ddp_partner.sv
// Partner model: descriptor memory of 32 beats and a dispatcher queue of eight.
// Assumes the prefetcher's memory and dispatcher ports on the one clock.
`timescale 1ns/1ps
`default_nettype none
module ddp_partner (
	// Clock and reset
	input  wire logic               mclk,
	input  wire logic               rst,
	// Memory side
	input  wire logic               rd_req,
	input  wire logic [63:0]        rd_addr,
	output logic                    rd_gnt,
	output logic                    rd_valid,
	output logic      [255:0]       rd_data,
	input  wire logic               wr_req,
	input  wire logic [63:0]        wr_addr,
	input  wire logic [255:0]       wr_data,
	input  wire logic [31:0]        wr_be,
	output logic                    wr_gnt,
	// Dispatcher side
	input  wire logic               dsp_valid,
	input  wire ddp_pkg::ddp_disp_t dsp_desc,
	output logic                    dsp_ready,
	output logic                    rsp_valid,
	output ddp_pkg::ddp_rsp_t       rsp_info,
	input  wire logic               rsp_ready,
	input  wire logic               hold_rsp,
	// Counters
	output var int                  n_dsp,
	output var int                  n_wb,
	output var int                  stray
);
	logic [255:0]       mem [0:31];
	ddp_pkg::ddp_disp_t got [0:15];
	ddp_pkg::ddp_disp_t q [$];
	logic               rpend;
	logic [4:0]         ridx;
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			{rd_gnt, rd_valid, wr_gnt, dsp_ready, rsp_valid, rpend} <= 6'h00;
			rd_data <= '0;
			rsp_info <= '0;
			ridx <= 5'h00;
			n_dsp <= 0;
			n_wb <= 0;
			stray <= 0;
			q.delete();
		end else begin
			// Grant a cycle late, one fetch at a time
			rd_gnt <= rd_req && !rd_gnt && !rpend;
			rd_valid <= rpend;
			// Idle data inverts every cycle, never repeating the previous cycle
			rd_data <= rpend ? mem[ridx] : ~rd_data;
			rpend <= rd_req && rd_gnt;
			if (rd_req && rd_gnt) begin
				ridx <= rd_addr[9:5];
				if (rd_addr[63:10] != 54'h0 || rd_addr[4:0] != 5'h00)
					stray <= stray + 1;
			end
			wr_gnt <= wr_req && !wr_gnt;
			if (wr_req && wr_gnt) begin
				for (int b = 0; b < 32; b++)
					if (wr_be[b])
						mem[wr_addr[9:5]][8 * b +: 8] <= wr_data[8 * b +: 8];
				n_wb <= n_wb + 1;
			end
			if (dsp_valid && dsp_ready) begin
				q.push_back(dsp_desc);
				got[n_dsp[3:0]] <= dsp_desc;
				n_dsp <= n_dsp + 1;
			end
			// Responses in order; bench may stall them to fill the queue
			if (rsp_valid && rsp_ready) begin
				void'(q.pop_front());
				rsp_valid <= 1'b0;
				rsp_info <= ~rsp_info;
			end else if (!rsp_valid && q.size() > 0 && !hold_rsp) begin
				rsp_valid <= 1'b1;
				rsp_info <= {q[0].len ^ 32'h1, q[0].len[7:0], q[0].len[8]};
			end
			dsp_ready <= q.size() < 8;
		end
	end
endmodule // ddp_partner
`default_nettype wire

// ===== testbench.sv
// Bench for the descriptor prefetcher: registers, list walk, park, polling, full queue.
// Assumes the partner model on the memory and dispatcher ports.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic               mclk = 1'b0, rst = 1'b0, psel = 1'b0, penable = 1'b0;
	logic               pwrite = 1'b0, hold = 1'b0, e;
	logic [7:0]         paddr = 8'h00;
	logic [31:0]        pwdata = 32'h0, prdata, wr_be, r;
	logic               pready, pslverr, rd_req, rd_gnt, rd_valid, wr_req, wr_gnt;
	logic               dsp_valid, dsp_ready, rsp_valid, rsp_ready;
	logic [63:0]        rd_addr, wr_addr;
	logic [255:0]       rd_data, wr_data;
	ddp_pkg::ddp_disp_t dsp_desc;
	ddp_pkg::ddp_rsp_t  rsp_info;
	int                 n_dsp, n_wb, stray, mismatches = 0, n_checks = 0;
	always #2 mclk = ~mclk;
	ddp_prefetcher ddp_prefetcher_i (.MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .RD_REQ(rd_req), .RD_ADDR(rd_addr), .RD_GNT(rd_gnt),
		.RD_VALID(rd_valid), .RD_DATA(rd_data), .WR_REQ(wr_req), .WR_ADDR(wr_addr),
		.WR_DATA(wr_data), .WR_BE(wr_be), .WR_GNT(wr_gnt), .DSP_VALID(dsp_valid),
		.DSP_DESC(dsp_desc), .DSP_READY(dsp_ready), .RSP_VALID(rsp_valid),
		.RSP_INFO(rsp_info), .RSP_READY(rsp_ready));
	ddp_partner ddp_partner_i (.mclk(mclk), .rst(rst), .rd_req(rd_req), .rd_addr(rd_addr),
		.rd_gnt(rd_gnt), .rd_valid(rd_valid), .rd_data(rd_data), .wr_req(wr_req),
		.wr_addr(wr_addr), .wr_data(wr_data), .wr_be(wr_be), .wr_gnt(wr_gnt),
		.dsp_valid(dsp_valid), .dsp_desc(dsp_desc), .dsp_ready(dsp_ready),
		.rsp_valid(rsp_valid), .rsp_info(rsp_info), .rsp_ready(rsp_ready),
		.hold_rsp(hold), .n_dsp(n_dsp), .n_wb(n_wb), .stray(stray));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic stuck();
		mismatches++;
		$display("wrong value wait expected done seen timeout");
		give_verdict();
	endtask
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Read data and error land in r and e
	task automatic apb(input logic w, input logic [5:0] i, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
			stuck();
	endtask
	task automatic wait_cnt(input logic dsp, input int want);
		int n;
		n = 0;
		while ((dsp ? n_dsp : n_wb) < want && n < 4000) begin
			@(posedge mclk);
			n++;
		end
		if (n >= 4000)
			stuck();
		else
			repeat (40) @(posedge mclk);
	endtask
	// Descriptor i always links to slot i+1
	task automatic put(input int i, input logic [31:0] len, input logic [31:0] c);
		ddp_partner_i.mem[i] = {c, 32'h66666666, 32'h55555555, 32'h44444444,
			32'(i + 1) << 5, len, 32'h1000 + 32'(i), 32'h2000 + 32'(i)};
	endtask
	task automatic chk_wb(input int i, input logic [31:0] len, input logic [31:0] c,
		input logic park);
		logic [255:0] m;
		m = ddp_partner_i.mem[i];
		chk("bytes", len ^ 32'h1, m[159:128]);
		chk("status", {23'h0, len[8:0]}, m[191:160]);
		chk("control", park ? c : c & 32'hbfffffff, m[255:224]);
		chk("kept", {32'h66666666, 32'(i + 1) << 5}, {m[223:192], m[127:96]});
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic s_regs();
		for (int k = 0; k < 5; k++) begin
			apb(1'b0, 6'(k), 32'h0);
			chk("reset value", 64'h0, {e, r});
		end
		for (int k = 1; k < 4; k++) begin
			apb(1'b1, 6'(k), 32'h20 + 32'(k));
			apb(1'b0, 6'(k), 32'h0);
			chk("readback", 64'h20 + 64'(k), {e, r});
		end
		apb(1'b1, 6'h00, 32'hffffffe8);
		apb(1'b0, 6'h00, 32'h0);
		chk("control spare", 64'h0, {e, r});
		apb(1'b1, 6'h05, 32'h1);
		apb(1'b0, 6'h05, 32'h0);
		chk("unmapped", 64'h100000000, {e, r});
		apb(1'b1, 6'h03, 32'h3);
	endtask
	task automatic s_walk();
		for (int k = 1; k < 4; k++)
			put(k, 32'h81 * k, 32'hc0000f00 + k);
		put(4, 32'h10, 32'h00000f00);
		apb(1'b1, 6'h01, 32'h20);
		apb(1'b1, 6'h00, 32'h1);
		wait_cnt(1'b0, 3);
		chk("dispatched", 64'd3, 64'(n_dsp));
		for (int k = 1; k < 4; k++) begin
			chk_wb(k, 32'h81 * k, 32'hc0000f00 + k, 1'b0);
			chk("disp", {32'h2000 + k, 32'h80000f00 + k}, {ddp_partner_i.got[k - 1].raddr,
				ddp_partner_i.got[k - 1].ctrl & 32'hbfffffff});
		end
		chk("stray", 64'h0, 64'(stray));
		apb(1'b0, 6'h04, 32'h0);
		chk("status end", 64'h4, {e, r});
		apb(1'b0, 6'h00, 32'h0);
		chk("run cleared", 64'h0, {e, r});
	endtask
	task automatic s_park();
		put(5, 32'h90, 32'hc0000005);
		put(6, 32'h111, 32'hc0000006);
		put(7, 32'h10, 32'h0);
		apb(1'b1, 6'h01, 32'ha0);
		apb(1'b1, 6'h00, 32'h11);
		wait_cnt(1'b0, 5);
		chk_wb(5, 32'h90, 32'hc0000005, 1'b1);
		chk_wb(6, 32'h111, 32'hc0000006, 1'b1);
		apb(1'b1, 6'h00, 32'h0);
	endtask
	task automatic s_poll();
		// Slot 8 starts unowned, so the fetch after slot 7 sees a defined word
		put(8, 32'h10, 32'h0);
		apb(1'b1, 6'h01, 32'he0);
		apb(1'b1, 6'h00, 32'h3);
		repeat (30) @(posedge mclk);
		chk("unowned held", 64'd5, 64'(n_dsp));
		ddp_partner_i.mem[7][254] = 1'b1;
		wait_cnt(1'b0, 6);
		chk_wb(7, 32'h10, 32'h40000000, 1'b0);
		apb(1'b0, 6'h01, 32'h0);
		chk("latest low", 64'h100, {e, r});
		apb(1'b0, 6'h02, 32'h0);
		chk("latest high", 64'h0, {e, r});
	endtask
	task automatic s_fill();
		hold <= 1'b1;
		put(18, 32'h10, 32'h0);
		for (int k = 8; k < 18; k++)
			put(k, 32'h20 + k, 32'hc0000000);
		wait_cnt(1'b1, 14);
		chk("queue full", 64'd14, 64'(n_dsp));
		apb(1'b0, 6'h04, 32'h0);
		chk("buffered", 64'h8, {60'h0, r[11:8]});
		hold <= 1'b0;
		wait_cnt(1'b0, 16);
		for (int k = 8; k < 18; k++)
			chk_wb(k, 32'h20 + k, 32'hc0000000, 1'b0);
	endtask
	initial begin
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		s_regs();
		s_walk();
		s_park();
		s_poll();
		s_fill();
		give_verdict();
	end
endmodule // testbench
`default_nettype wire
